// *** design/ebct_pkg.sv ***
// Package with constants and types of the external bus cycle timing block.
package ebct_pkg;

  // ---------------------------------------------------------------------------
  // Window configuration
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_WIN        = 4;
  localparam int unsigned CFG_NUM        = NUM_WIN + 1;
  localparam int unsigned CFG_IDX_W      = 3;
  localparam logic [2:0]  CFG_DEFAULT    = 3'h0;
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned WAIT_W         = 4;
  localparam logic [3:0]  WAIT_MAX       = 4'hf;
  localparam int unsigned RDY_MODE_BIT   = 3;
  localparam logic [3:0]  WAIT_RST       = 4'h0;
  localparam logic        STRETCH_RST_DEF = 1'b1;
  localparam logic        STRETCH_RST_WIN = 1'b0;
  localparam logic        FLOAT_DIS_RST  = 1'b0;
  localparam logic        CMD_DIS_RST    = 1'b0;
  localparam logic        HSK_RST        = 1'b0;
  localparam logic        MUX_RST        = 1'b1;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned HALF_CLK_NS    = 25;
  localparam int unsigned SYNC_STAGES    = 3;
  localparam int unsigned FLOAT_TICKS    = 2;

  // Cycle phases; each state lasts one half CPU clock except IDLE, WAIT, RDY and the two float states.
  typedef enum logic [3:0] {
    EBCT_IDLE,
    EBCT_ALE,
    EBCT_ALE_EXT,
    EBCT_HOLD,
    EBCT_HOLD_EXT,
    EBCT_CMD_DLY,
    EBCT_WAIT,
    EBCT_RDY,
    EBCT_XFER,
    EBCT_FLOAT_IMP,
    EBCT_FLOAT_PRG
  } ebct_state_t;

endpackage : ebct_pkg

// *** design/ebct_cfg_reg.sv ***
// One configuration register set, default or window, with its reset values.
`timescale 1ns/1ps
`default_nettype none
module ebct_cfg_reg
  import ebct_pkg::*;
#(
  parameter logic STRETCH_RST = STRETCH_RST_WIN
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              cfg_we,
  input  wire logic              stretch_in,
  input  wire logic [WAIT_W-1:0] wait_in,
  input  wire logic              float_dis_in,
  input  wire logic              cmd_dis_in,
  input  wire logic              hsk_in,
  input  wire logic              mux_in,
  output logic                   stretch_q,
  output logic      [WAIT_W-1:0] wait_q,
  output logic                   float_dis_q,
  output logic                   cmd_dis_q,
  output logic                   hsk_q,
  output logic                   mux_q
);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stretch_q   <= STRETCH_RST;
      wait_q      <= WAIT_RST;
      float_dis_q <= FLOAT_DIS_RST;
      cmd_dis_q   <= CMD_DIS_RST;
      hsk_q       <= HSK_RST;
      mux_q       <= MUX_RST;
    end else if (cfg_we) begin
      stretch_q   <= stretch_in;
      wait_q      <= wait_in;
      float_dis_q <= float_dis_in;
      cmd_dis_q   <= cmd_dis_in;
      hsk_q       <= hsk_in;
      mux_q       <= mux_in;
    end
  end

endmodule : ebct_cfg_reg
`default_nettype wire

// *** design/ebct_top.sv ***
// External bus cycle timing controller with per-window configuration.
//
// Operation
// [R1] Stretch bit set lengthens the latch strobe by half a CPU clock.
// [R2] Multiplexed stretch also lengthens address hold; data moves one clock later.
// [R3] Default config stretch bit resets to one, window stretch bits to zero.
// [R4] Insert fifteen minus the cycle wait count wait states, one clock each.
// [R5] CPU stalls during wait states when it needs the pending access.
// [R6] Float-wait disable low inserts one clock before the next address.
// [R7] Float wait stalls only a following external access, not the CPU; an internal access is still acked only after it ends.
// [R8] Multiplexed cycles add one implicit float wait on top of programmed one.
// [R9] Command delay puts strobe half a clock after latch falls, else coincident.
// [R10] Command delay applies when its disable bit is zero; resets to zero.
// [R11] Command delay keeps memory cycle time and overall length unchanged.
// [R12] Software should enable command delay for multiplexed windows.
// [R13] Handshake mode uses low three wait bits, then samples ready.
// [R14] Wait count bit three picks direct or synchronised ready sampling.
// [R15] External device pulls ready low when data latched or valid.
// [R16] External device may release ready on the strobe rising edge.
// [R17] Handshake cycles wait for ready indefinitely; only reset ends them.
// [R18] Clock output should be enabled for synchronous ready use.
// [R19] Asynchronous ready is sampled earlier and costs synchroniser wait states.
// [R20] Cycle ends at the first ready sample that sees ready active.
// [R21] Internal accesses run at full speed, no external timing applies; during a float wait their ack waits until it ends.
// [R22] Timing of the matching one of four windows, else the default config.
// [R23] Asynchronous ready passes a synchroniser on the CPU clock first.
`timescale 1ns/1ps
`default_nettype none
module ebct_top
  import ebct_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  // Configuration write port: index 0 is the default config, 1..4 the windows.
  input  wire logic                            cfg_we,
  input  wire logic [CFG_IDX_W-1:0]            cfg_sel,
  input  wire logic                            cfg_latch_strobe_stretch,
  input  wire logic [WAIT_W-1:0]               cfg_cycle_wait_count,
  input  wire logic                            cfg_float_wait_disable,
  input  wire logic                            cfg_command_delay_disable,
  input  wire logic                            cfg_handshake_enable,
  input  wire logic                            cfg_mux_mode,
  // Window address select: base and mask per window, flattened.
  input  wire logic [NUM_WIN*ADDR_W-1:0]       window_address_select_base,
  input  wire logic [NUM_WIN*ADDR_W-1:0]       window_address_select_mask,
  // Access request from the core.
  input  wire logic                            acc_req,
  input  wire logic                            acc_internal,
  input  wire logic [ADDR_W-1:0]               acc_addr,
  input  wire logic                            acc_needed,
  output logic                                 acc_ack,
  output logic                                 cpu_stall,
  // Pins; command strobe low active, address latch strobe high active.
  input  wire logic                            ready_n,
  output logic                                 addr_latch_strobe,
  output logic                                 cmd_strobe_n,
  output logic                                 addr_drive,
  output logic                                 bus_float,
  // Readback of the configuration selected by cfg_sel, plus the busy status.
  output logic                                 stat_latch_strobe_stretch,
  output logic [WAIT_W-1:0]                    stat_cycle_wait_count,
  output logic                                 stat_float_wait_disable,
  output logic                                 stat_command_delay_disable,
  output logic                                 stat_handshake_enable,
  output logic                                 stat_busy
);

  // ---------------------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------------------
  logic [CFG_NUM-1:0]        str_v;
  logic [CFG_NUM-1:0]        fdis_v;
  logic [CFG_NUM-1:0]        cdis_v;
  logic [CFG_NUM-1:0]        hsk_v;
  logic [CFG_NUM-1:0]        mux_v;
  logic [WAIT_W-1:0]         wait_v [CFG_NUM];

  genvar g;
  generate
    for (g = 0; g < CFG_NUM; g++) begin : g_cfg
      ebct_cfg_reg #(
        .STRETCH_RST ((g == 0) ? STRETCH_RST_DEF : STRETCH_RST_WIN) // [R3]
      ) u_cfg (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .cfg_we       (cfg_we && (cfg_sel == CFG_IDX_W'(g))),
        .stretch_in   (cfg_latch_strobe_stretch),
        .wait_in      (cfg_cycle_wait_count),
        .float_dis_in (cfg_float_wait_disable),
        .cmd_dis_in   (cfg_command_delay_disable),
        .hsk_in       (cfg_handshake_enable),
        .mux_in       (cfg_mux_mode),
        .stretch_q    (str_v[g]),
        .wait_q       (wait_v[g]),
        .float_dis_q  (fdis_v[g]),
        .cmd_dis_q    (cdis_v[g]),
        .hsk_q        (hsk_v[g]),
        .mux_q        (mux_v[g])
      );
    end
  endgenerate

  wire logic [CFG_IDX_W-1:0] rd_idx = (cfg_sel < CFG_IDX_W'(CFG_NUM)) ? cfg_sel : CFG_DEFAULT;
  assign stat_latch_strobe_stretch  = str_v[rd_idx];
  assign stat_cycle_wait_count      = wait_v[rd_idx];
  assign stat_float_wait_disable    = fdis_v[rd_idx];
  assign stat_command_delay_disable = cdis_v[rd_idx];
  assign stat_handshake_enable      = hsk_v[rd_idx];

  // ---------------------------------------------------------------------------
  // Window decode
  // ---------------------------------------------------------------------------
  // Lower windows win when several match, so overlapping windows stay defined.
  logic [CFG_IDX_W-1:0] hit_idx;
  always_comb begin
    hit_idx = CFG_DEFAULT;
    for (int i = NUM_WIN - 1; i >= 0; i--) begin
      if (((acc_addr ^ window_address_select_base[i*ADDR_W +: ADDR_W])
           & window_address_select_mask[i*ADDR_W +: ADDR_W]) == '0) begin
        hit_idx = CFG_IDX_W'(i + 1); // [R22]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Ready synchroniser
  // ---------------------------------------------------------------------------
  // Three stages; the state is only taken when the last two agree.
  logic [SYNC_STAGES-1:0] rdy_sync_q;
  logic                   rdy_async_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdy_sync_q  <= '1;
      rdy_async_q <= 1'b1;
    end else begin
      rdy_sync_q <= {rdy_sync_q[SYNC_STAGES-2:0], ready_n}; // [R23]
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
        rdy_async_q <= rdy_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------------------
  // Half-clock phases are emulated: the sequencer runs one state per clk_sys,
  // where clk_sys stands for the CPU half period. Each wait state is two ticks.
  ebct_state_t          st_q, st_d;
  logic [CFG_IDX_W-1:0] cur_q, cur_d;
  logic [WAIT_W:0]      cnt_q, cnt_d;
  logic                 fprg_q, fprg_d;

  wire logic             c_str   = str_v[cur_q];
  wire logic             c_mux   = mux_v[cur_q];
  wire logic             c_hsk   = hsk_v[cur_q];
  wire logic             c_cdis  = cdis_v[cur_q];
  wire logic             c_fdis  = fdis_v[cur_q];
  wire logic [WAIT_W-1:0] c_wait = wait_v[cur_q];
  wire logic             c_async = c_wait[RDY_MODE_BIT];

  // Handshake mode counts only the low three bits and inverts them alike.
  wire logic [WAIT_W-1:0] wait_hsk = {1'b0, ~c_wait[RDY_MODE_BIT-1:0]};
  wire logic [WAIT_W-1:0] wait_nrm = WAIT_MAX - c_wait; // [R4]
  wire logic [WAIT_W-1:0] wait_sel = c_hsk ? wait_hsk : wait_nrm; // [R13]
  wire logic [WAIT_W:0]   wait_ticks = {wait_sel, 1'b0};

  // Direct ready is the pin sampled once; the async path is the filtered one.
  logic rdy_direct_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdy_direct_q <= 1'b1;
    end else begin
      rdy_direct_q <= ready_n;
    end
  end
  wire logic rdy_seen = c_async ? ~rdy_async_q : ~rdy_direct_q; // [R14] [R19]

  wire logic start_ext = acc_req && !acc_internal;
  wire logic idle      = (st_q == EBCT_IDLE);
  wire logic in_float  = (st_q == EBCT_FLOAT_IMP) || (st_q == EBCT_FLOAT_PRG);

  always_comb begin
    st_d   = st_q;
    cur_d  = cur_q;
    cnt_d  = cnt_q;
    fprg_d = fprg_q;
    unique case (st_q)
      EBCT_IDLE: begin
        if (start_ext) begin
          cur_d = hit_idx; // [R22]
          st_d  = EBCT_ALE;
        end
      end
      EBCT_ALE: begin
        st_d = c_str ? EBCT_ALE_EXT : EBCT_HOLD; // [R1]
      end
      EBCT_ALE_EXT: begin
        st_d = EBCT_HOLD;
      end
      EBCT_HOLD: begin
        // Address hold extension only exists when address and data share pins.
        st_d  = (c_str && c_mux) ? EBCT_HOLD_EXT : EBCT_CMD_DLY; // [R2]
        cnt_d = wait_ticks;
      end
      EBCT_HOLD_EXT: begin
        st_d = EBCT_CMD_DLY; // [R2]
      end
      EBCT_CMD_DLY: begin
        // The delay phase is present either way; only the strobe moves inside it.
        st_d = (cnt_q != '0) ? EBCT_WAIT : (c_hsk ? EBCT_RDY : EBCT_XFER); // [R11]
      end
      EBCT_WAIT: begin
        cnt_d = cnt_q - (WAIT_W + 1)'(1);
        if (cnt_q == (WAIT_W + 1)'(1)) begin
          st_d = c_hsk ? EBCT_RDY : EBCT_XFER; // [R4]
        end
      end
      EBCT_RDY: begin
        // No timeout here: a missing ready holds the cycle until reset.
        if (rdy_seen) begin
          st_d = EBCT_XFER; // [R17] [R20]
        end
      end
      EBCT_XFER: begin
        fprg_d = !c_fdis; // [R6]
        if (c_mux) begin
          st_d = EBCT_FLOAT_IMP; // [R8]
        end else if (!c_fdis) begin
          st_d = EBCT_FLOAT_PRG; // [R6]
        end else begin
          st_d = EBCT_IDLE;
        end
        cnt_d = (WAIT_W + 1)'(FLOAT_TICKS);
      end
      EBCT_FLOAT_IMP, EBCT_FLOAT_PRG: begin
        cnt_d = cnt_q - (WAIT_W + 1)'(1);
        if (cnt_q == (WAIT_W + 1)'(1)) begin
          cnt_d = (WAIT_W + 1)'(FLOAT_TICKS);
          if (st_q == EBCT_FLOAT_IMP && fprg_q) begin
            st_d = EBCT_FLOAT_PRG; // [R8]
          end else begin
            st_d   = EBCT_IDLE;
            fprg_d = 1'b0;
          end
        end
      end
      default: st_d = EBCT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q   <= EBCT_IDLE;
      cur_q  <= CFG_DEFAULT;
      cnt_q  <= '0;
      fprg_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      cnt_q  <= cnt_d;
      fprg_q <= fprg_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Without the delay the command falls with the latch strobe, inside the address hold.
  wire logic cmd_next  = (st_d == EBCT_HOLD_EXT) || (st_d == EBCT_CMD_DLY)
                         || (st_d == EBCT_WAIT) || (st_d == EBCT_RDY) || (st_d == EBCT_XFER);
  wire logic cmd_early = (st_d == EBCT_HOLD) && c_cdis; // [R9] [R10]

  logic ale_q, cmd_n_q, addr_q, float_q, ack_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ale_q   <= 1'b0;
      cmd_n_q <= 1'b1;
      addr_q  <= 1'b0;
      float_q <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      ale_q   <= (st_d == EBCT_ALE) || (st_d == EBCT_ALE_EXT);
      cmd_n_q <= !(cmd_next || cmd_early); // [R9]
      addr_q  <= (st_d == EBCT_ALE) || (st_d == EBCT_ALE_EXT) || (st_d == EBCT_HOLD)
                 || (st_d == EBCT_HOLD_EXT);
      float_q <= (st_d == EBCT_FLOAT_IMP) || (st_d == EBCT_FLOAT_PRG);
      // Internal accesses complete at once when the sequencer is idle, with no external phases; a float wait holds them off.
      ack_q   <= (acc_req && acc_internal && idle) || (st_q == EBCT_XFER); // [R21]
    end
  end

  assign addr_latch_strobe = ale_q;
  assign cmd_strobe_n      = cmd_n_q;
  assign addr_drive        = addr_q;
  assign bus_float         = float_q;
  assign acc_ack           = ack_q;
  assign stat_busy         = !idle;

  // The float phase stalls only a following external access; a busy cycle
  // stalls the core only when it waits on this very access.
  // The request that ack_q answers still stands and must not count as the next one.
  assign cpu_stall = (acc_needed && !idle && !in_float) // [R5]
                   || (start_ext && acc_needed && in_float && !ack_q); // [R7]

endmodule : ebct_top
`default_nettype wire

// *** verif/ebct_checker.sv ***
// Concurrent checks on the ports of the external bus cycle timing block.
`timescale 1ns/1ps
`default_nettype none
module ebct_checker
  import ebct_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic acc_req,
  input wire logic acc_internal,
  input wire logic acc_needed,
  input wire logic acc_ack,
  input wire logic cpu_stall,
  input wire logic addr_latch_strobe,
  input wire logic cmd_strobe_n,
  input wire logic addr_drive,
  input wire logic bus_float,
  input wire logic stat_busy
);
  // ---------------------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Reset must park the strobes even while it is still held.
  a_reset_strobes_idle: assert property (disable iff (1'b0)
    sys_rst |=> !addr_latch_strobe && cmd_strobe_n && !acc_ack)
    else $error("strobes or ack active after reset");
  a_ack_single_pulse: assert property (acc_ack |=> !acc_ack)
    else $error("ack longer than one cycle");
  a_ack_with_request: assert property (acc_ack |-> $past(acc_req))
    else $error("ack without a pending request");
  a_latch_no_command: assert property (addr_latch_strobe |-> cmd_strobe_n)
    else $error("command active during latch strobe");
  a_latch_strobe_len: assert property ($rose(addr_latch_strobe) |-> ##[1:2] !addr_latch_strobe)
    else $error("latch strobe too long");
  a_latch_to_cmd: assert property ($fell(addr_latch_strobe) |-> ##[0:1] !cmd_strobe_n)
    else $error("command not following latch strobe");
  a_latch_drives_addr: assert property (addr_latch_strobe |-> addr_drive)
    else $error("address not driven during latch strobe");
  a_float_quiet_bus: assert property (bus_float |-> !addr_latch_strobe && cmd_strobe_n)
    else $error("strobe active during float wait");
  a_stall_has_cause: assert property (cpu_stall |-> acc_req && acc_needed)
    else $error("stall without a needed access");
  a_internal_full_speed: assert property (
    $rose(acc_req) && acc_internal && !stat_busy |-> ##[1:2] acc_ack)
    else $error("internal access not at full speed");
  a_internal_no_strobe: assert property (
    $rose(acc_req) && acc_internal && !stat_busy |=> !addr_latch_strobe [*2])
    else $error("internal access started an external cycle");
endmodule : ebct_checker

bind ebct_top ebct_checker u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .acc_req(acc_req), .acc_internal(acc_internal),
  .acc_needed(acc_needed), .acc_ack(acc_ack), .cpu_stall(cpu_stall),
  .addr_latch_strobe(addr_latch_strobe), .cmd_strobe_n(cmd_strobe_n),
  .addr_drive(addr_drive), .bus_float(bus_float), .stat_busy(stat_busy)
);
`default_nettype wire

// *** verif/ebct_ext_dev.sv ***
// Model of an external peripheral answering bus cycles with a low-active ready.
`timescale 1ns/1ps
`default_nettype none
module ebct_ext_dev (
  input  wire logic       clk_sys,
  input  wire logic       cmd_strobe_n,
  input  wire logic [7:0] ready_delay,
  input  wire logic       never_ready,
  output var  logic       ready_n
);
  // ---------------------------------------------------------------------------
  // Ready response
  // ---------------------------------------------------------------------------
  int unsigned cnt_q = 0;
  initial ready_n = 1'b1;
  always @(posedge clk_sys) begin
    // A released line falls back to its pull-up level, never the last value.
    if (cmd_strobe_n || never_ready) begin
      cnt_q <= 0;
      ready_n <= 1'b1;
    end else if (cnt_q >= ready_delay) begin
      ready_n <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : ebct_ext_dev
`default_nettype wire

// *** verif/tb_ebct_top.sv ***
// Self-checking bench for the external bus cycle timing block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_ebct_top
  import ebct_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Stimulus, monitor and run control
  // ---------------------------------------------------------------------------
  logic clk_sys = 0, sys_rst = 1, cfg_we = 0, c_s = 0, c_fd = 0, c_cd = 0, c_h = 0, c_m = 0;
  logic [2:0] cfg_sel = 0;
  logic [3:0] c_w = 0, st_w;
  logic [NUM_WIN*ADDR_W-1:0] wbase = {24'h400000, 24'h300000, 24'h200000, 24'h100000};
  logic [NUM_WIN*ADDR_W-1:0] wmask = {4{24'hf00000}};
  logic acc_req = 0, acc_int = 0, acc_need = 0, never = 0, st = 0, pa = 0, pc = 1, pf = 0;
  logic [ADDR_W-1:0] acc_addr = 0;
  logic [7:0] rdly = 0;
  logic acc_ack, stall, ready_n, ale, cmd_n, adrv, bflt, st_s, st_fd, st_cd, st_h, busy;
  int fails = 0, n_tests = 0, cyc = 0, t0, t_ale, t_f, e, s, m, fd, cd, w, nd, la, lb, lc;
  int lat_q[$], cmd_q[$], flt_q[$];
  bit meas = 1;

  ebct_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_latch_strobe_stretch(c_s), .cfg_cycle_wait_count(c_w), .cfg_float_wait_disable(c_fd),
    .cfg_command_delay_disable(c_cd), .cfg_handshake_enable(c_h), .cfg_mux_mode(c_m),
    .window_address_select_base(wbase), .window_address_select_mask(wmask),
    .acc_req(acc_req), .acc_internal(acc_int), .acc_addr(acc_addr), .acc_needed(acc_need),
    .acc_ack(acc_ack), .cpu_stall(stall), .ready_n(ready_n), .addr_latch_strobe(ale),
    .cmd_strobe_n(cmd_n), .addr_drive(adrv), .bus_float(bflt),
    .stat_latch_strobe_stretch(st_s), .stat_cycle_wait_count(st_w),
    .stat_float_wait_disable(st_fd), .stat_command_delay_disable(st_cd),
    .stat_handshake_enable(st_h), .stat_busy(busy));
  ebct_ext_dev u_dev (.clk_sys(clk_sys), .cmd_strobe_n(cmd_n), .ready_delay(rdly),
    .never_ready(never), .ready_n(ready_n));

  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Outputs are judged at the falling edge, where every registered value has settled.
  always @(negedge clk_sys) begin
    if (acc_ack === 1'b1 && lat_q.size() > 0) begin
      e = lat_q.pop_front();
      if (e >= 0) `CHK("latency", e, cyc - t0)
    end
    if (pa && !ale) t_ale = cyc;
    if (pc && !cmd_n && meas && cmd_q.size() > 0) begin
      e = cmd_q.pop_front();
      `CHK("cmd delay", e, cyc - t_ale)
    end
    if (!pf && bflt) t_f = cyc;
    if (pf && !bflt && meas && flt_q.size() > 0) begin
      e = flt_q.pop_front();
      `CHK("float ticks", e, cyc - t_f)
    end
    {pa, pc, pf} = {ale, cmd_n, bflt};
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic cfg(input int sel, input int s1, input int w1, input int f1, input int d1,
                     input int h1, input int m1);
    @(negedge clk_sys);
    {cfg_sel, c_s, c_w, c_fd, c_cd, c_h, c_m} = {sel[2:0], s1[0], w1[3:0], f1[0], d1[0], h1[0],
                                                 m1[0]};
    cfg_we = 1;
    @(negedge clk_sys);
    cfg_we = 0;
  endtask : cfg

  task automatic access(input int in1, input int a, input int n1, input int el, output int lat);
    int k;
    @(negedge clk_sys);
    lat_q.push_back(el);
    {acc_int, acc_addr, acc_need, acc_req, st} = {in1[0], a[23:0], n1[0], 1'b1, 1'b0};
    t0 = cyc;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
      st |= stall;
    end while (acc_ack !== 1'b1 && k < 400);
    lat = cyc - t0;
    acc_req = 0;
    if (k >= 400) begin
      fails++;
      tally_and_finish();
    end
    for (k = 0; busy !== 1'b0 && k < 100; k++) @(negedge clk_sys);
    if (busy !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
  endtask : access

  task automatic chk_rst;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys);
      cfg_sel = i[2:0];
      #1;
      `CHK("stretch rst", (i == 0), st_s)
      `CHK("wait rst", 4'h0, st_w)
      `CHK("flag rst", 3'h0, {st_fd, st_cd, st_h})
    end
    $display("Test reset values done");
  endtask : chk_rst

  initial begin
    void'($urandom(32'h14df));
    repeat (10) @(negedge clk_sys);
    sys_rst = 0;
    chk_rst();
    access(1, 24'h800000, 1, 1, la);
    cmd_q.push_back(1);
    flt_q.push_back(4);
    access(0, 24'h800000, 1, 37, la);
    $display("Test internal and default cycle done");
    repeat (6) begin
      {s, m, fd, cd, nd, w} = {$urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2,
                               $urandom % 2, $urandom % 16};
      cd = cd & (1 - m);
      cfg(0, s, w, fd, cd, 0, m);
      cmd_q.push_back(1 - cd);
      if (fd == 0 || m == 1) flt_q.push_back(2 * (1 - fd) + 2 * m);
      access(0, 24'h800000 + ($urandom % 24'h7ffff), nd, 5 + s + (m & s) + 2 * (15 - w), la);
      if (nd == 0 || w != 15) `CHK("stall", nd[0], st)
    end
    $display("Test random timing done");
    cfg(1, 0, 15, 1, 0, 0, 0);
    cmd_q.push_back(1);
    access(0, 24'h1abcde, 0, 5, la);
    cmd_q.push_back(1);
    flt_q.push_back(4);
    access(0, 24'h2abcde, 0, 35, la);
    $display("Test windows done");
    meas = 0;
    cfg(1, 0, 6, 1, 0, 1, 0);
    access(0, 24'h100000, 0, -1, la);
    cfg(1, 0, 0, 1, 0, 1, 0);
    access(0, 24'h100000, 0, -1, lb);
    `CHK("hs waits", la + 12, lb)
    cfg(1, 0, 14, 1, 0, 1, 0);
    access(0, 24'h100000, 0, -1, lc);
    `CHK("async slower", 1'b1, lc > la)
    rdly = 8'h14;
    cfg(1, 0, 6, 1, 0, 1, 0);
    access(0, 24'h100000, 0, -1, lc);
    `CHK("ready waited", 1'b1, lc > la + 15)
    $display("Test handshake done");
    never = 1;
    @(negedge clk_sys);
    {acc_req, st} = 2'b10;
    repeat (100) begin
      @(negedge clk_sys);
      st |= acc_ack;
    end
    `CHK("hang ack", 1'b0, st)
    `CHK("hang busy", 1'b1, busy)
    {acc_req, sys_rst} = 2'b01;
    repeat (10) @(negedge clk_sys);
    {sys_rst, never} = 2'b00;
    chk_rst();
    tally_and_finish();
  end
endmodule : tb_ebct_top
`default_nettype wire
